// File: logic/temp_monitor_pkg.sv
// constants shared by the temperature monitor status block
// assumes a classic wishbone slave with byte-wide register index addressing
package temp_monitor_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_REMOTE_ONE = 8'h25;
   localparam logic [7:0] IDX_INTERNAL = 8'h26;
   localparam logic [7:0] IDX_REMOTE_TWO = 8'h27;
   localparam logic [7:0] IDX_EVENT_ONE = 8'h41;
   localparam logic [7:0] IDX_LOW_BITS_ONE = 8'h85;
   localparam logic [7:0] IDX_LOW_BITS_TWO = 8'h86;
   localparam logic [7:0] IDX_CONFIG = 8'h7F;
   // chosen: enables, limits and the control index ending the limit range
   localparam logic [7:0] IDX_EVENT_ENABLE = 8'hC0;
   localparam logic [7:0] IDX_LIMIT_BASE = 8'hC1;
   localparam logic [7:0] IDX_CONTROL = 8'hC7;
   // configuration field positions
   localparam int CFG_RUN_BIT = 0;
   localparam int CFG_READY_BIT = 1;
   // event status field positions
   localparam int EV_SUMMARY_BIT = 7;
   localparam int EV_REMOTE_TWO_BIT = 6;
   localparam int EV_INTERNAL_BIT = 5;
   localparam int EV_REMOTE_ONE_BIT = 4;
   // reset values
   localparam logic [7:0] EVENT_ONE_RESET = 8'h00;
   localparam logic [7:0] ENABLE_RESET = 8'hFF;
   localparam logic [7:0] LIMIT_HIGH_RESET = 8'h7F;
   localparam logic [7:0] LIMIT_LOW_RESET = 8'h81;
   localparam logic [7:0] SENSOR_ERROR = 8'h80;
   // timing
   localparam longint CLK_HZ = 20000000;
   localparam longint STARTUP_US = 301500;
   localparam longint STARTUP_CYCLES = CLK_HZ * STARTUP_US / 1000000;
   localparam longint REFRESH_HZ = 4;
   localparam longint REFRESH_CYCLES = CLK_HZ / REFRESH_HZ;
endpackage

// File: logic/temp_monitor_status.sv
// temperature reading registers and event status one
// assumes converter results arrive as 12-bit words with a strobe on clk_i
// What this block does
// [RQ1] three read-only readings at 25h, 26h, 27h
// [RQ2] 12-bit signed; upper byte, low bits 85h-86h
// [RQ3] absent or faulty remote diode reads 80h
// [RQ4] readings refresh at least at 4Hz
// [RQ5] writes to reading registers are ignored
// [RQ6] zones one, two, three map to sensors
// [RQ7] software reads upper byte before low bits
// [RQ8] readings invalid 301.5ms after run; ready flag
// [RQ9] stopped: fans full on, no monitoring
// [RQ10] tach readings continue while stopped
// [RQ11] stopped: no status bits are set
// [RQ12] running: monitoring uses current registers, sets status
// [RQ13] registers keep contents when run clears
// [RQ14] event status one layout at 41h, reset 00h
// [RQ15] status one resets on power good rising
// [RQ16] bit 7 read-only summary of status two
// [RQ17] flags sticky until write one or disable
// [RQ18] temp flag clears on write one if quiet
// [RQ19] voltage flag auto-clears after write once quiet
// [RQ20] no events when stopped or disabled
// [RQ21] disable clears flag now, or at next run
// [RQ22] compare each fresh reading against limits
module temp_monitor_status #(
   parameter longint STARTUP_CYCLES = temp_monitor_pkg::STARTUP_CYCLES,
   parameter longint REFRESH_CYCLES = temp_monitor_pkg::REFRESH_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [9:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // converter results, same clock
   input wire logic sample_valid_i,
   input wire logic [11:0] remote_one_sample_i,
   input wire logic [11:0] internal_sample_i,
   input wire logic [11:0] remote_two_sample_i,
   input wire logic remote_one_fault_i,
   input wire logic remote_two_fault_i,
   // voltage violation levels and status two summary, same clock
   input wire logic [3:0] volt_violation_i,
   input wire logic status_two_any_i,
   // supply power good pin, asynchronous
   input wire logic supply_power_good_i,
   // zone temperatures and fan override
   output logic [7:0] zone_one_temp_o,
   output logic [7:0] zone_two_temp_o,
   output logic [7:0] zone_three_temp_o,
   output logic fans_full_on_o,
   output logic monitor_run_o
);
   // readings: upper byte and low nibble of each sensor
   logic [11:0] reading_r [3];
   // enable, limits (high, low per sensor), config
   logic [7:0] enable_r;
   logic [7:0] limit_hi_r [3];
   logic [7:0] limit_lo_r [3];
   logic run_r;
   logic ready_r;
   logic [6:0] flag_r;
   logic [3:0] volt_armed_r;
   logic [2:0] temp_viol_r;
   logic [38:0] startup_cnt_r;
   logic [38:0] refresh_cnt_r;
   logic pg_meta_r;
   logic pg_sync_r;
   logic pg_prev_r;
   logic [7:0] idx;
   logic wr_stb;
   logic [7:0] wbyte;
   logic [6:0] wr_one;
   logic [6:0] violate;

   // decode register index from word address
   assign idx = adr_i[9:2];
   assign wbyte = dat_i[7:0];
   // a write lands at the edge where the master sees ack high
   assign wr_stb = cyc_i & stb_i & we_i & ack_o & sel_i[0];

   // 8-bit signed compare of upper byte against a limit window
   function automatic logic out_of_range(input logic [7:0] v,
         input logic [7:0] hi, input logic [7:0] lo);
      out_of_range = ($signed(v) > $signed(hi)) |
         ($signed(v) < $signed(lo));
   endfunction

   // limit pair slot from a register index in the limit range
   function automatic logic [1:0] limit_slot(input logic [7:0] i);
      limit_slot = 2'((i - temp_monitor_pkg::IDX_LIMIT_BASE) >> 1);
   endfunction

   // bus acknowledge, one cycle after request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= cyc_i & stb_i & ~ack_o;
      end
   end

   // read data mux; unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (cyc_i & stb_i & ~ack_o) begin
         dat_o <= 32'h0000_0000;
         case (idx)
            temp_monitor_pkg::IDX_REMOTE_ONE:
               dat_o[7:0] <= reading_r[0][11:4]; // see [RQ1]
            temp_monitor_pkg::IDX_INTERNAL:
               dat_o[7:0] <= reading_r[1][11:4];
            temp_monitor_pkg::IDX_REMOTE_TWO:
               dat_o[7:0] <= reading_r[2][11:4];
            temp_monitor_pkg::IDX_LOW_BITS_ONE:
               // low nibbles of remote two and remote one
               dat_o[7:0] <= {reading_r[2][3:0],
                  reading_r[0][3:0]}; // see [RQ2]
            temp_monitor_pkg::IDX_LOW_BITS_TWO:
               dat_o[7:0] <= {4'h0, reading_r[1][3:0]};
            temp_monitor_pkg::IDX_EVENT_ONE:
               dat_o[7:0] <= {status_two_any_i, flag_r}; // see [RQ16]
            temp_monitor_pkg::IDX_EVENT_ENABLE:
               dat_o[7:0] <= enable_r;
            temp_monitor_pkg::IDX_CONFIG:
               dat_o[7:0] <= {6'h00, ready_r, run_r};
            default: begin
               if (idx >= temp_monitor_pkg::IDX_LIMIT_BASE &&
                   idx < temp_monitor_pkg::IDX_CONTROL) begin
                  // odd index is the low limit, even the high
                  dat_o[7:0] <= idx[0] ? limit_lo_r[limit_slot(idx)] :
                     limit_hi_r[limit_slot(idx)];
               end
            end
         endcase
      end
   end

   // run bit and enable and limit registers; held across stop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_r <= 1'b0;
         enable_r <= temp_monitor_pkg::ENABLE_RESET;
         for (int i = 0; i < 3; i++) begin
            limit_hi_r[i] <= temp_monitor_pkg::LIMIT_HIGH_RESET;
            limit_lo_r[i] <= temp_monitor_pkg::LIMIT_LOW_RESET;
         end
      end else if (wr_stb) begin // see [RQ13]
         if (idx == temp_monitor_pkg::IDX_CONFIG) begin
            run_r <= wbyte[temp_monitor_pkg::CFG_RUN_BIT];
         end
         if (idx == temp_monitor_pkg::IDX_EVENT_ENABLE) begin
            enable_r <= wbyte;
         end
         for (int i = 0; i < 3; i++) begin
            if (idx == 8'(temp_monitor_pkg::IDX_LIMIT_BASE + 2 * i)) begin
               limit_lo_r[i] <= wbyte;
            end
            if (idx == 8'(temp_monitor_pkg::IDX_LIMIT_BASE + 2 * i + 1)) begin
               limit_hi_r[i] <= wbyte;
            end
         end
      end
   end

   // start-up counter and ready flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         startup_cnt_r <= 39'h0;
         ready_r <= 1'b0;
      end else begin
         if (!run_r) begin
            startup_cnt_r <= 39'h0;
            ready_r <= 1'b0;
         end else if (startup_cnt_r < 39'(STARTUP_CYCLES - 1)) begin
            startup_cnt_r <= startup_cnt_r + 39'h1;
         end else begin
            ready_r <= 1'b1; // see [RQ8]
         end
      end
   end

   // reading capture; refresh forced if converter stalls
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 3; i++) begin
            reading_r[i] <= {temp_monitor_pkg::SENSOR_ERROR, 4'h0};
         end
         refresh_cnt_r <= 39'h0;
         temp_viol_r <= 3'h0;
      end else if (run_r) begin // see [RQ9]
         if (sample_valid_i ||
             refresh_cnt_r >= 39'(REFRESH_CYCLES - 1)) begin // see [RQ4]
            refresh_cnt_r <= 39'h0;
            reading_r[0] <= remote_one_fault_i ?
               {temp_monitor_pkg::SENSOR_ERROR, 4'h0} :
               remote_one_sample_i; // see [RQ3]
            reading_r[1] <= internal_sample_i;
            reading_r[2] <= remote_two_fault_i ?
               {temp_monitor_pkg::SENSOR_ERROR, 4'h0} :
               remote_two_sample_i;
            temp_viol_r[0] <= remote_one_fault_i |
               out_of_range(remote_one_sample_i[11:4],
               limit_hi_r[0], limit_lo_r[0]); // see [RQ22]
            temp_viol_r[1] <= out_of_range(internal_sample_i[11:4],
               limit_hi_r[1], limit_lo_r[1]);
            temp_viol_r[2] <= remote_two_fault_i |
               out_of_range(remote_two_sample_i[11:4],
               limit_hi_r[2], limit_lo_r[2]);
         end else begin
            refresh_cnt_r <= refresh_cnt_r + 39'h1;
         end
      end else begin
         refresh_cnt_r <= 39'h0;
      end
   end

   // power good synchroniser and edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // idle level of the pin is high: no false edge after reset
         pg_meta_r <= 1'b1;
         pg_sync_r <= 1'b1;
         pg_prev_r <= 1'b1;
      end else begin
         pg_meta_r <= supply_power_good_i;
         pg_sync_r <= pg_meta_r;
         pg_prev_r <= pg_sync_r;
      end
   end

   // bits 6..4 remote two, internal, remote one; bits 3..0 rails
   assign violate = {temp_viol_r[2], temp_viol_r[1], temp_viol_r[0],
      volt_violation_i};
   assign wr_one = (wr_stb && idx == temp_monitor_pkg::IDX_EVENT_ONE) ?
      wbyte[6:0] : 7'h00; // see [RQ5]

   // voltage flags armed for auto-clear after a write of one
   always_ff @(posedge clk_i) begin
      if (rst_i || (pg_sync_r && !pg_prev_r)) begin
         volt_armed_r <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (!flag_r[i]) begin
               volt_armed_r[i] <= 1'b0;
            end else if (wr_one[i]) begin
               volt_armed_r[i] <= 1'b1; // see [RQ19]
            end
         end
      end
   end

   // sticky event flags; set wins over write-one clear, disable wins over set
   always_ff @(posedge clk_i) begin
      if (rst_i || (pg_sync_r && !pg_prev_r)) begin // see [RQ15]
         flag_r <= temp_monitor_pkg::EVENT_ONE_RESET[6:0]; // see [RQ14]
      end else if (run_r) begin // see [RQ11]
         for (int i = 0; i < 7; i++) begin
            if (!enable_r[i]) begin
               flag_r[i] <= 1'b0; // see [RQ21]
            end else if (violate[i] && ready_r) begin
               flag_r[i] <= 1'b1; // see [RQ12]
            end else if (i >= 4 && wr_one[i] && !violate[i]) begin
               flag_r[i] <= 1'b0; // see [RQ18]
            end else if (i < 4 && (wr_one[i] || volt_armed_r[i])) begin
               flag_r[i] <= 1'b0; // see [RQ17]
            end
         end
      end else begin
         for (int i = 0; i < 7; i++) begin
            if (wr_one[i] && !(i >= 4 && violate[i])) begin
               flag_r[i] <= 1'b0; // see [RQ20]
            end
         end
      end
   end

   // zone outputs and fan override
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         zone_one_temp_o <= temp_monitor_pkg::SENSOR_ERROR;
         zone_two_temp_o <= temp_monitor_pkg::SENSOR_ERROR;
         zone_three_temp_o <= temp_monitor_pkg::SENSOR_ERROR;
         fans_full_on_o <= 1'b1;
         monitor_run_o <= 1'b0;
      end else begin
         zone_one_temp_o <= reading_r[0][11:4]; // see [RQ6]
         zone_two_temp_o <= reading_r[1][11:4];
         zone_three_temp_o <= reading_r[2][11:4];
         fans_full_on_o <= ~run_r; // see [RQ9]
         monitor_run_o <= run_r; // see [RQ10]
      end
   end

   // assertions
   property p_ack_one;
      @(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one) // see [RQ1]
      else $error("ack held");

   property p_stopped_fans;
      @(posedge clk_i) disable iff (rst_i)
      !run_r |=> fans_full_on_o;
   endproperty
   a_stopped_fans: assert property (p_stopped_fans) // see [RQ9]
      else $error("fans not full on while stopped");

   property p_no_set_stopped;
      @(posedge clk_i) disable iff (rst_i)
      !run_r |=> (flag_r & ~$past(flag_r)) == 7'h00;
   endproperty
   a_no_set_stopped: assert property (p_no_set_stopped) // see [RQ11]
      else $error("flag set while stopped");

   property p_disable_clears;
      @(posedge clk_i) disable iff (rst_i)
      (run_r && !enable_r[4]) |=> !flag_r[4];
   endproperty
   a_disable_clears: assert property (p_disable_clears) // see [RQ21]
      else $error("disabled flag not cleared");

   property p_ready_low_stopped;
      @(posedge clk_i) disable iff (rst_i)
      !run_r |=> !ready_r;
   endproperty
   a_ready_low_stopped: assert property (p_ready_low_stopped) // see [RQ8]
      else $error("ready while stopped");

   property p_pg_reset;
      @(posedge clk_i) disable iff (rst_i)
      (pg_sync_r && !pg_prev_r) |=> flag_r == 7'h00;
   endproperty
   a_pg_reset: assert property (p_pg_reset) // see [RQ15]
      else $error("status not reset on power good");

   property p_sticky;
      @(posedge clk_i) disable iff (rst_i)
      (run_r && flag_r[5] && enable_r[5] && wr_one[5] == 1'b0
         && !(pg_sync_r && !pg_prev_r)) |=> flag_r[5];
   endproperty
   a_sticky: assert property (p_sticky) // see [RQ17]
      else $error("flag dropped without clear");

   property p_temp_keep;
      @(posedge clk_i) disable iff (rst_i)
      (run_r && enable_r[6] && violate[6] && ready_r) |=> flag_r[6];
   endproperty
   a_temp_keep: assert property (p_temp_keep) // see [RQ18]
      else $error("active temp flag cleared");

   property p_zone_map;
      @(posedge clk_i) disable iff (rst_i)
      ##1 zone_two_temp_o == $past(reading_r[1][11:4]);
   endproperty
   a_zone_map: assert property (p_zone_map) // see [RQ6]
      else $error("zone two mismatch");

   // quiet temperature flag written one must clear
   sequence s_quiet_write;
      run_r && enable_r[5] && !violate[5] && wr_one[5];
   endsequence
   sequence s_flag_gone;
      !flag_r[5];
   endsequence
   property p_quiet_clear;
      @(posedge clk_i) disable iff (rst_i)
      s_quiet_write |=> s_flag_gone;
   endproperty
   a_quiet_clear: assert property (p_quiet_clear) // see [RQ18]
      else $error("quiet temp flag not cleared");

   // faulty remote diode reads the sensor-error code
   property p_fault_code;
      @(posedge clk_i) disable iff (rst_i)
      (run_r && sample_valid_i && remote_two_fault_i) |=>
         reading_r[2][11:4] == temp_monitor_pkg::SENSOR_ERROR;
   endproperty
   a_fault_code: assert property (p_fault_code) // see [RQ3]
      else $error("fault code missing");

   // forced capture keeps the refresh interval bounded
   property p_refresh_bound;
      @(posedge clk_i) disable iff (rst_i)
      refresh_cnt_r < 39'(REFRESH_CYCLES);
   endproperty
   a_refresh_bound: assert property (p_refresh_bound) // see [RQ4]
      else $error("refresh interval exceeded");
endmodule

// File: testbench/sensor_model.sv
// far-side converter model: periodic 12-bit samples and a diode fault
// assumes the bench sets the wanted values; one strobe each PERIOD cycles
module sensor_model #(
   parameter int PERIOD = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // values the bench wants converted
   input wire logic [11:0] r1_set_i,
   input wire logic [11:0] in_set_i,
   input wire logic [11:0] r2_set_i,
   input wire logic f1_set_i,
   // converter results
   output logic sample_valid_o,
   output logic [11:0] r1_o,
   output logic [11:0] in_o,
   output logic [11:0] r2_o,
   output logic f1_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt; // cycles since last strobe
   logic hit; // strobe cycle
   assign hit = (cnt == PERIOD - 1);
   // 12-bit signed words valid only with the strobe, inverted between
   always_ff @(posedge clk_i) begin
      cnt <= (rst_i || hit) ? 0 : cnt + 1;
      sample_valid_o <= !rst_i && hit;
      r1_o <= hit ? r1_set_i : ~r1_set_i;
      in_o <= hit ? in_set_i : ~in_set_i;
      r2_o <= hit ? r2_set_i : ~r2_set_i;
      f1_o <= f1_set_i;
   end
endmodule

// File: testbench/temp_monitor_status_tb.sv
// self-checking bench for the temperature reading and event status block
// assumes the converter model on the far side and a classic bus master here
module temp_monitor_status_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, sample_valid_i;
   logic [9:0] adr_i;
   logic [3:0] sel_i, volt_violation_i;
   logic [31:0] dat_i, dat_o;
   logic [11:0] r1, in, r2, r1_set, in_set, r2_set;
   logic f1, f1_set, f2, status_two_any_i, supply_power_good_i;
   logic [7:0] zone_one_temp_o, zone_two_temp_o, zone_three_temp_o;
   logic fans_full_on_o, monitor_run_o;
   int errors = 0;
   int cmp_count = 0;
   // far side
   sensor_model sensor_u (.clk_i(clk_i), .rst_i(rst_i), .r1_set_i(r1_set),
      .in_set_i(in_set), .r2_set_i(r2_set), .f1_set_i(f1_set),
      .sample_valid_o(sample_valid_i), .r1_o(r1), .in_o(in), .r2_o(r2),
      .f1_o(f1));
   // short start-up and refresh counts
   temp_monitor_status #(.STARTUP_CYCLES(20), .REFRESH_CYCLES(50)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .sample_valid_i(sample_valid_i),
      .remote_one_sample_i(r1), .internal_sample_i(in),
      .remote_two_sample_i(r2), .remote_one_fault_i(f1),
      .remote_two_fault_i(f2), .volt_violation_i(volt_violation_i),
      .status_two_any_i(status_two_any_i),
      .supply_power_good_i(supply_power_good_i),
      .zone_one_temp_o(zone_one_temp_o), .zone_two_temp_o(zone_two_temp_o),
      .zone_three_temp_o(zone_three_temp_o),
      .fans_full_on_o(fans_full_on_o), .monitor_run_o(monitor_run_o));
   // compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one classic cycle: hold until ack, then one idle cycle
   task automatic wb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {idx, 2'b00};
      sel_i <= 4'hF;
      dat_i <= {24'h000000, wd};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (n >= 20) chk(8'hEE, 8'h00);
      rd = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] x;
      wb(1'b1, idx, d, x);
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] x;
      wb(1'b0, idx, 8'h00, x);
      chk(x, exp);
   endtask
   // let a few converter strobes pass
   task automatic settle;
      repeat (3) @(posedge clk_i iff sample_valid_i);
      repeat (3) @(posedge clk_i);
   endtask
   // poll the configuration register until readings are valid
   task automatic wait_ready;
      logic [7:0] d;
      int n;
      n = 0;
      d = 8'h00;
      while (d[1] !== 1'b1 && n < 40) begin
         wb(1'b0, 8'h7F, 8'h00, d);
         n++;
      end
      chk(d & 8'h03, 8'h03);
   endtask
   // reset values, an unmapped index and limit defaults
   task automatic t_reset;
      rdchk(8'h41, 8'h00);
      chk({7'h00, fans_full_on_o}, 8'h01);
      rdchk(8'h10, 8'h00);
      rdchk(8'hC0, 8'hFF);
      rdchk(8'hC1, 8'h81);
      rdchk(8'hC2, 8'h7F);
   endtask
   // start, readings, low bits, zones, ignored write
   task automatic t_run;
      logic [7:0] d;
      wr(8'h7F, 8'h01);
      wb(1'b0, 8'h7F, 8'h00, d);
      chk(d & 8'h02, 8'h00);
      wait_ready();
      settle();
      rdchk(8'h25, 8'h12);
      rdchk(8'h26, 8'h45);
      rdchk(8'h27, 8'h78);
      rdchk(8'h85, 8'h93);
      rdchk(8'h86, 8'h06);
      chk(zone_one_temp_o, 8'h12);
      chk(zone_two_temp_o, 8'h45);
      chk(zone_three_temp_o, 8'h78);
      chk({6'h00, monitor_run_o, fans_full_on_o}, 8'h02);
      wr(8'h25, 8'hAA);
      rdchk(8'h25, 8'h12);
   endtask
   // internal limit violation, sticky, write-one only when quiet
   task automatic t_temp;
      wr(8'hC4, 8'h30);
      rdchk(8'hC4, 8'h30);
      rdchk(8'hC3, 8'h81);
      settle();
      rdchk(8'h41, 8'h20);
      wr(8'h41, 8'h20);
      rdchk(8'h41, 8'h20);
      in_set <= 12'h100;
      settle();
      rdchk(8'h41, 8'h20);
      wr(8'h41, 8'h20);
      rdchk(8'h41, 8'h00);
      wr(8'hC4, 8'h7F);
      f1_set <= 1'b1;
      f2 <= 1'b1;
      settle();
      rdchk(8'h25, 8'h80);
      rdchk(8'h27, 8'h80);
      rdchk(8'h41, 8'h50);
      chk(zone_three_temp_o, 8'h80);
      f1_set <= 1'b0;
      f2 <= 1'b0;
      settle();
      wr(8'h41, 8'h50);
      rdchk(8'h41, 8'h00);
   endtask
   // voltage flags: sticky, cleared now or once quiet
   task automatic t_volt;
      volt_violation_i <= 4'h8;
      settle();
      volt_violation_i <= 4'h0;
      settle();
      rdchk(8'h41, 8'h08);
      wr(8'h41, 8'h08);
      rdchk(8'h41, 8'h00);
      volt_violation_i <= 4'h1;
      settle();
      wr(8'h41, 8'h01);
      rdchk(8'h41, 8'h01);
      volt_violation_i <= 4'h0;
      settle();
      rdchk(8'h41, 8'h00);
      status_two_any_i <= 1'b1;
      settle();
      wr(8'h41, 8'h80);
      rdchk(8'h41, 8'h80);
      status_two_any_i <= 1'b0;
      settle();
      rdchk(8'h41, 8'h00);
      volt_violation_i <= 4'h2;
      settle();
      wr(8'hC0, 8'hFD);
      rdchk(8'h41, 8'h00);
      settle();
      rdchk(8'h41, 8'h00);
      volt_violation_i <= 4'h0;
      wr(8'hC0, 8'hFF);
   endtask
   // stop: no new flags, held readings, deferred disable, power good
   task automatic t_stop;
      volt_violation_i <= 4'h4;
      settle();
      wr(8'h7F, 8'h00);
      volt_violation_i <= 4'hC;
      r1_set <= 12'h555;
      wr(8'hC0, 8'hFB);
      settle();
      rdchk(8'h41, 8'h04);
      chk({6'h00, monitor_run_o, fans_full_on_o}, 8'h01);
      rdchk(8'h25, 8'h12);
      volt_violation_i <= 4'h0;
      wr(8'h7F, 8'h01);
      rdchk(8'h41, 8'h00);
      wait_ready();
      volt_violation_i <= 4'h8;
      settle();
      volt_violation_i <= 4'h0;
      rdchk(8'h41, 8'h08);
      supply_power_good_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      supply_power_good_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rdchk(8'h41, 8'h00);
   endtask
   task automatic end_of_test;
      if (errors == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // clock
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      end_of_test();
   end
   // main sequence
   initial begin
      {rst_i, cyc_i, stb_i, we_i, f1_set, f2, status_two_any_i} = 7'h40;
      {adr_i, sel_i, dat_i, volt_violation_i} = '0;
      {r1_set, in_set, r2_set} = {12'h123, 12'h456, 12'h789};
      supply_power_good_i = 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_run();
      t_temp();
      t_volt();
      t_stop();
      end_of_test();
   end
endmodule
